/* File: logic/timer_capture_compare_pwm.sv */
// timer/counter with capture, compare and pwm channels on an ahb-lite slave
// Function
// - narrow unit: 16-bit counter, four channels
// - wide unit: same, 32-bit counter and values
// - each channel: capture, compare or pwm
// - capture copies counter on selected event
// - compare output toggles when counter meets value
// - pwm waveform follows written compare values
// - dead time only in unit zero
// - count clocks or external events, software selects
// - event pulses go to routing network
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module timer_capture_compare_pwm #(
  parameter int CNT_W = 16, // 16 narrow unit, 32 wide unit
  parameter int NUM_CH = 4, // channels, at most four
  parameter int UNIT_INDEX = 0 // unit number within its kind
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state
  input tmr_pkg::ahb_req_s ahb_i, // ahb-lite request signals
  input wire logic hready, // bus ready
  output tmr_pkg::ahb_rsp_s ahb_o, // ahb-lite response signals
  input wire logic cnt_evt_in, // external count event pin
  input wire logic [NUM_CH-1:0] cap_in, // capture input pins
  output logic [NUM_CH-1:0] ch_out, // channel outputs
  output logic [NUM_CH-1:0] ch_out_n, // complementary outputs
  output logic [NUM_CH:0] evt_out, // event pulses, bit 0 overflow
  output logic irq // interrupt level
);
  import tmr_pkg::*;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // widen a counter-sized value to a bus word
  function automatic logic [31:0] to_word(input logic [CNT_W-1:0] v);
    logic [31:0] w;
    w = '0;
    w[CNT_W-1:0] = v;
    return w;
  endfunction
  // address lies in the region of an existing channel
  function automatic logic ch_addr(input logic [7:0] a);
    return ((a & CH_REGION_MASK) == OFS_CH_BASE) && (int'(a[4:CH_IDX_LSB]) < NUM_CH);
  endfunction
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic run; // counter enabled
  logic src_ext; // count external events
  logic dt_en; // dead-time insertion on
  logic [CNT_W-1:0] top; // wrap value
  logic [CNT_W-1:0] count; // the counter
  logic [NUM_CH:0] status; // sticky events
  logic [NUM_CH:0] mask; // interrupt enables
  logic [DT_W-1:0] dtime; // dead time in cycles
  chan_cfg_s ch_cfg [NUM_CH]; // channel configs
  logic [CNT_W-1:0] ch_val [NUM_CH]; // channel values
  logic [NUM_CH-1:0] wave; // raw channel waveforms
  logic [NUM_CH-1:0] ch_hit; // channel event pulses
  logic [NUM_CH-1:0] cap_rise; // capture input rose
  logic [NUM_CH-1:0] cap_fall; // capture input fell
  logic [NUM_CH-1:0] wr_val; // value write strobes
  logic cnt_rise; // external count event
  logic tick; // counter advances
  logic wrap; // counter wraps
  logic addr_ok; // valid address phase
  logic wr_pend; // write data phase pending
  logic [7:0] wr_addr; // latched write address
  logic [7:0] rd_addr; // address of this address phase
  logic [31:0] next_rdata; // read mux
  logic [31:0] hrdata; // registered read data
  logic [NUM_CH:0] ev_set; // events this cycle
  logic [NUM_CH:0] ev_clr; // status read clears
  logic wdt; // any write data phase
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  in_filter u_cnt_in (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .din(cnt_evt_in),
    .level(),
    .rise(cnt_rise),
    .fall()
  );
  for (genvar i = 0; i < NUM_CH; i++) begin : g_cap
    in_filter u_cap (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .din(cap_in[i]),
      .level(),
      .rise(cap_rise[i]),
      .fall(cap_fall[i])
    );
  end
  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  // zero wait states: every transfer completes in its first data cycle
  assign addr_ok = ahb_i.hsel && hready && ahb_i.htrans[1];
  assign rd_addr = ahb_i.haddr[7:0];
  assign wdt = wr_pend && hready;
  assign ahb_o.hrdata = hrdata;
  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp = 1'b0;
  // latch the address phase of a write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce) begin
      wr_pend <= addr_ok && ahb_i.hwrite;
      if (addr_ok) begin
        wr_addr <= rd_addr;
      end
    end
  end
  // read mux on the address phase; unmapped words read zero
  always_comb begin
    next_rdata = '0;
    if (rd_addr == OFS_CTRL) begin
      next_rdata[CTRL_RUN] = run;
      next_rdata[CTRL_EXT] = src_ext;
      next_rdata[CTRL_DTEN] = dt_en;
    end else if (rd_addr == OFS_TOP) begin
      next_rdata = to_word(top);
    end else if (rd_addr == OFS_COUNT) begin
      next_rdata = to_word(count);
    end else if (rd_addr == OFS_STATUS) begin
      next_rdata[NUM_CH:0] = status;
    end else if (rd_addr == OFS_MASK) begin
      next_rdata[NUM_CH:0] = mask;
    end else if (rd_addr == OFS_DTIME) begin
      next_rdata[DT_W-1:0] = dtime;
    end else if (ch_addr(rd_addr)) begin
      if (rd_addr[CH_VAL_BIT]) begin
        next_rdata = to_word(ch_val[rd_addr[4:CH_IDX_LSB]]);
      end else begin
        next_rdata[CHC_W-1:0] = ch_cfg[rd_addr[4:CH_IDX_LSB]];
      end
    end
  end
  // read data register, presented in the data phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (ce) begin
      if (addr_ok && !ahb_i.hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // dead-time enable stays zero outside unit 0
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run <= 1'b0;
      src_ext <= 1'b0;
      dt_en <= 1'b0;
      top <= RST_TOP[CNT_W-1:0];
      mask <= '0;
      dtime <= RST_DTIME;
    end else if (ce && wdt) begin
      if (wr_addr == OFS_CTRL) begin
        run <= ahb_i.hwdata[CTRL_RUN];
        src_ext <= ahb_i.hwdata[CTRL_EXT];
        dt_en <= (UNIT_INDEX == 0) && ahb_i.hwdata[CTRL_DTEN];
      end else if (wr_addr == OFS_TOP) begin
        top <= ahb_i.hwdata[CNT_W-1:0];
      end else if (wr_addr == OFS_MASK) begin
        mask <= ahb_i.hwdata[NUM_CH:0];
      end else if (wr_addr == OFS_DTIME) begin
        dtime <= ahb_i.hwdata[DT_W-1:0];
      end
    end
  end
  // channel config words
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_cfg[i] <= '{edge_sel: EDGE_RISE, mode: MODE_OFF};
      end
    end else if (ce && wdt && ch_addr(wr_addr) && !wr_addr[CH_VAL_BIT]) begin
      ch_cfg[wr_addr[4:CH_IDX_LSB]] <= chan_cfg_s'(ahb_i.hwdata[CHC_W-1:0]);
    end
  end
  // value write strobes per channel
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      wr_val[i] = wdt && ch_addr(wr_addr) && wr_addr[CH_VAL_BIT] && (int'(wr_addr[4:CH_IDX_LSB]) == i);
    end
  end
  // ----------------------------------------
  // counter
  // ----------------------------------------
  assign tick = run && (src_ext ? cnt_rise : 1'b1);
  assign wrap = tick && (count == top);
  // a software write of the count wins over counting
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      if (wdt && wr_addr == OFS_COUNT) begin
        count <= ahb_i.hwdata[CNT_W-1:0];
      end else if (wrap) begin
        count <= '0;
      end else if (tick) begin
        count <= count + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // channels
  // ----------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    cc_channel #(
      .W(CNT_W)
    ) u_ch (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .cfg(ch_cfg[i]),
      .count(count),
      .tick(tick),
      .wrap(wrap),
      .in_rise(cap_rise[i]),
      .in_fall(cap_fall[i]),
      .wr_val(wr_val[i]),
      .wdata(ahb_i.hwdata[CNT_W-1:0]),
      .value(ch_val[i]),
      .wave(wave[i]),
      .hit(ch_hit[i])
    );
  end
  // ----------------------------------------
  // status, interrupt and event outputs
  // ----------------------------------------
  assign ev_set = {ch_hit, wrap};
  assign ev_clr = (addr_ok && !ahb_i.hwrite && rd_addr == OFS_STATUS) ? status : '0;
  // set wins over the read clear, so no event is lost
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~ev_clr) | ev_set;
    end
  end
  // interrupt follows status one cycle later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status & mask);
    end
  end
  // event pulses toward the routing network
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_out <= '0;
    end else if (ce) begin
      evt_out <= ev_set;
    end
  end
  // ----------------------------------------
  // output stage and dead time
  // ----------------------------------------
  if (UNIT_INDEX == 0) begin : g_dt
    logic [DT_W-1:0] dt_cnt [NUM_CH]; // remaining gap cycles
    logic [NUM_CH-1:0] last; // waveform being driven
    // on each change both outputs go low for dtime+1 cycles, which trades
    // a little pulse width for never driving both sides at once
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        for (int i = 0; i < NUM_CH; i++) begin
          dt_cnt[i] <= '0;
        end
        last <= '0;
        ch_out <= '0;
        ch_out_n <= '0;
      end else if (ce) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (!dt_en) begin
            dt_cnt[i] <= '0;
            last[i] <= wave[i];
            ch_out[i] <= wave[i];
            ch_out_n[i] <= ~wave[i];
          end else if (wave[i] != last[i]) begin
            last[i] <= wave[i];
            dt_cnt[i] <= dtime;
            ch_out[i] <= 1'b0;
            ch_out_n[i] <= 1'b0;
          end else if (dt_cnt[i] != '0) begin
            dt_cnt[i] <= dt_cnt[i] - 1'b1;
          end else begin
            ch_out[i] <= last[i];
            ch_out_n[i] <= ~last[i];
          end
        end
      end
    end
    a_dead_gap: assert property (@(posedge clock) disable iff (!rst_n)
      dt_en |-> (ch_out & ch_out_n) == '0)
      else $error("both complementary outputs high");
  end else begin : g_nodt
    // plain complementary pair, no gap logic in this unit
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        ch_out <= '0;
        ch_out_n <= '0;
      end else if (ce) begin
        ch_out <= wave;
        ch_out_n <= ~wave;
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_wrap_zero: assert property (@(posedge clock) disable iff (!rst_n)
    ce && wrap && !(wdt && wr_addr == OFS_COUNT) |=> count == '0)
    else $error("counter did not wrap to zero");
  a_count_step: assert property (@(posedge clock) disable iff (!rst_n)
    ce && tick && !wrap && !(wdt && wr_addr == OFS_COUNT) |=> count == $past(count) + 1'b1)
    else $error("counter did not advance by one");
  a_ovf_flag: assert property (@(posedge clock) disable iff (!rst_n)
    ce && wrap |=> status[ST_OVF])
    else $error("wrap without overflow flag");
  a_ext_hold: assert property (@(posedge clock) disable iff (!rst_n)
    ce && run && src_ext && !cnt_rise && !(wdt && wr_addr == OFS_COUNT) |=> count == $past(count))
    else $error("counted without an external event");
  a_event_out: assert property (@(posedge clock) disable iff (!rst_n)
    ce |=> evt_out == $past(ev_set))
    else $error("event pulse does not follow its cause");
  a_chan_flag: assert property (@(posedge clock) disable iff (!rst_n)
    ce && ch_hit[0] |=> status[ST_CH_LSB])
    else $error("channel event without flag");
  a_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
    ce ##1 ce |=> irq == |($past(status & mask)))
    else $error("interrupt level wrong");
  c_wrap: cover property (@(posedge clock) disable iff (!rst_n) ce && wrap);
  c_capture: cover property (@(posedge clock) disable iff (!rst_n) ch_cfg[0].mode == MODE_CAPTURE && ch_hit[0]);
  c_pwm_high: cover property (@(posedge clock) disable iff (!rst_n) ch_cfg[0].mode == MODE_PWM && $rose(wave[0]));
  c_read_clear: cover property (@(posedge clock) disable iff (!rst_n) ev_clr != '0);
endmodule

/* File: inc/tmr_pkg.sv */
// package: register map, field layout and types of the timer/counter unit
package tmr_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00; // run, count source, dead-time enable
  localparam logic [7:0] OFS_TOP = 8'h04; // wrap value of the counter
  localparam logic [7:0] OFS_COUNT = 8'h08; // counter, writable
  localparam logic [7:0] OFS_STATUS = 8'h0C; // sticky events, cleared by read
  localparam logic [7:0] OFS_MASK = 8'h10; // interrupt enables, same layout
  localparam logic [7:0] OFS_DTIME = 8'h14; // dead time in clock cycles
  localparam logic [7:0] OFS_CH_BASE = 8'h20; // first channel config word
  localparam logic [7:0] CH_REGION_MASK = 8'hE0; // selects the channel region
  localparam int CH_VAL_BIT = 2; // set: channel value word, clear: config word
  localparam int CH_IDX_LSB = 3; // channel index lives in addr[4:3]
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_RUN = 0; // counter runs
  localparam int CTRL_EXT = 1; // count external events instead of clocks
  localparam int CTRL_DTEN = 2; // dead-time insertion, unit 0 only
  localparam int ST_OVF = 0; // overflow flag
  localparam int ST_CH_LSB = 1; // channel flags start here
  localparam int CHC_W = 4; // width of a channel config word
  localparam int DT_W = 8; // width of the dead-time count
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] RST_TOP = 32'hFFFFFFFF; // full range until set
  localparam logic [DT_W-1:0] RST_DTIME = 8'h00; // shortest gap, one cycle when enabled
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // htrans[1] marks a transfer
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_OFF, MODE_CAPTURE, MODE_COMPARE, MODE_PWM} mode_e;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_NONE} edge_e;
  typedef struct packed {
    edge_e edge_sel; // capture edge, bits 3:2
    mode_e mode; // channel mode, bits 1:0
  } chan_cfg_s;
  typedef struct packed {
    logic hsel; // slave select
    logic [31:0] haddr; // byte address
    logic [1:0] htrans; // transfer type
    logic hwrite; // write when high
    logic [2:0] hsize; // only words are used
    logic [31:0] hwdata; // write data, data phase
  } ahb_req_s;
  typedef struct packed {
    logic [31:0] hrdata; // read data, data phase
    logic hreadyout; // always ready
    logic hresp; // always okay
  } ahb_rsp_s;
endpackage

/* File: logic/in_filter.sv */
// input synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module in_filter (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic din, // asynchronous input
  output logic level, // filtered level
  output logic rise, // one-cycle pulse on accepted rise
  output logic fall // one-cycle pulse on accepted fall
);
  logic s1; // first stage, read only by s2
  logic s2; // second stage
  logic s3; // third stage
  // ----------------------------------------
  // three-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // accept a change only when stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (ce) begin
      rise <= (s2 == s3) && s3 && !level;
      fall <= (s2 == s3) && !s3 && level;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

/* File: logic/cc_channel.sv */
// one capture / compare / pwm channel
`timescale 1ns/10ps
module cc_channel #(
  parameter int W = 16 // counter width
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input tmr_pkg::chan_cfg_s cfg, // mode and capture edge
  input wire logic [W-1:0] count, // running counter
  input wire logic tick, // counter advances this cycle
  input wire logic wrap, // counter wraps this cycle
  input wire logic in_rise, // capture input rose
  input wire logic in_fall, // capture input fell
  input wire logic wr_val, // software writes the value
  input wire logic [W-1:0] wdata, // value written
  output logic [W-1:0] value, // compare value or captured count
  output logic wave, // channel waveform
  output logic hit // one-cycle event pulse
);
  import tmr_pkg::*;
  logic [W-1:0] pwm_act; // threshold of the running pwm period
  logic cap_evt; // selected capture edge seen
  logic match; // counter meets the value
  // ----------------------------------------
  // event selection
  // ----------------------------------------
  always_comb begin
    case (cfg.edge_sel)
      EDGE_RISE: cap_evt = in_rise;
      EDGE_FALL: cap_evt = in_fall;
      EDGE_BOTH: cap_evt = in_rise | in_fall;
      default: cap_evt = 1'b0;
    endcase
  end
  assign match = tick && (count == value);
  // in capture mode only a capture loads the value; software writes are ignored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      value <= '0;
    end else if (ce) begin
      if (cfg.mode == MODE_CAPTURE && cap_evt) begin
        value <= count;
      end else if (wr_val && cfg.mode != MODE_CAPTURE) begin
        value <= wdata;
      end
    end
  end
  // pwm threshold reloads at wrap so a written value takes effect from the next period
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwm_act <= '0;
    end else if (ce) begin
      if (cfg.mode != MODE_PWM || wrap) begin
        pwm_act <= value;
      end
    end
  end
  // waveform per mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else if (ce) begin
      case (cfg.mode)
        MODE_COMPARE: begin
          if (match) begin
            wave <= ~wave;
          end
        end
        MODE_PWM: wave <= (count < pwm_act);
        default: wave <= 1'b0;
      endcase
    end
  end
  // event pulse for flags and the routing network
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else if (ce) begin
      hit <= (cfg.mode == MODE_CAPTURE) ? cap_evt : (cfg.mode != MODE_OFF) && match;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_capture_copy: assert property (@(posedge clock) disable iff (!rst_n)
    ce && cfg.mode == MODE_CAPTURE && cap_evt |=> value == $past(count))
    else $error("capture did not store the counter");
  a_compare_toggle: assert property (@(posedge clock) disable iff (!rst_n)
    ce && cfg.mode == MODE_COMPARE && match |=> wave != $past(wave))
    else $error("compare match did not toggle output");
  a_pwm_level: assert property (@(posedge clock) disable iff (!rst_n)
    ce && cfg.mode == MODE_PWM |=> wave == ($past(count) < $past(pwm_act)))
    else $error("pwm level wrong");
  a_hit_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    ce && cfg.mode == MODE_COMPARE && match |=> hit)
    else $error("compare match without event");
endmodule

/* File: verif/event_partner.sv */
// model of the event routing side: count and capture pins, wrap events
`timescale 1ns/10ps
module event_partner (
  input wire logic clock, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic cnt_req, // bench wants a count train
  input wire logic [3:0] cap_req, // bench wants capture levels
  input wire logic [4:0] evt_out, // timer event pulses
  output logic cnt_evt_in = 1'b0, // count pin
  output logic [3:0] cap_in = 4'h0, // capture pins
  output int n_edge = 0, // rising edges made
  output int n_ovf = 0 // wrap events seen
);
  int ph = 0; // phase in the 6-cycle train
  // ----------------------------------------
  // pins
  // ----------------------------------------
  // 3 high, 3 low: each level well over the two-cycle minimum
  always @(posedge clock) begin
    cap_in <= cap_req;
    if (!rst_n) begin
      ph <= 0;
      cnt_evt_in <= 1'b0;
    end else begin
      n_ovf <= n_ovf + evt_out[0];
      if (cnt_req || ph != 0) begin
        ph <= (ph + 1) % 6;
        cnt_evt_in <= ph < 3;
        if (ph == 0) n_edge <= n_edge + 1;
      end
    end
  end
endmodule

/* File: verif/timer_capture_compare_pwm_test.sv */
// self-checking bench of the timer/counter unit
`timescale 1ns/10ps
module timer_capture_compare_pwm_test;
  import tmr_pkg::*;
  logic clock = 0, rst_n = 0, ce = 1, cnt_req = 0, cnt_evt_in, irq;
  logic [3:0] cap_req = 0, cap_in, ch_out, ch_out_n;
  logic [4:0] evt_out;
  ahb_req_s ahb_i = '0; // bus request
  ahb_rsp_s ahb_o; // bus response
  int bad_count = 0, total_checks = 0, n_edge, n_ovf, h, z;
  logic [31:0] seed = 32'h0F48DDF4, rd, v, o;
  timer_capture_compare_pwm #(.CNT_W(16), .NUM_CH(4), .UNIT_INDEX(0)) DUT (
    .clock(clock), .rst_n(rst_n), .ce(ce), .ahb_i(ahb_i),
    .hready(ahb_o.hreadyout), .ahb_o(ahb_o), .cnt_evt_in(cnt_evt_in),
    .cap_in(cap_in), .ch_out(ch_out), .ch_out_n(ch_out_n), .evt_out(evt_out), .irq(irq));
  event_partner far (.clock(clock), .rst_n(rst_n), .cnt_req(cnt_req), .cap_req(cap_req),
    .evt_out(evt_out), .cnt_evt_in(cnt_evt_in), .cap_in(cap_in), .n_edge(n_edge), .n_ovf(n_ovf));
  initial begin
    forever #50 clock = ~clock;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one single word transfer, entered just after a rising edge
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    ahb_i.hsel <= 1'b1;
    ahb_i.haddr <= {24'h000000, a};
    ahb_i.htrans <= HTRANS_NONSEQ;
    ahb_i.hwrite <= wr;
    ahb_i.hsize <= 3'h2;
    do @(posedge clock); while (ahb_o.hreadyout !== 1'b1);
    ahb_i.htrans <= 2'h0;
    ahb_i.hwdata <= d;
    do @(posedge clock); while (ahb_o.hreadyout !== 1'b1);
    rd = ahb_o.hrdata;
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    tk(2);
    rst_n <= 1;
    tk(1);
    bus(0, OFS_TOP, 0);
    chk("top reset", 32'h0000FFFF, rd);
    bus(0, 8'h18, 0);
    chk("unmapped", 0, rd);
    chk("hresp okay", 0, ahb_o.hresp);
    // wrap, overflow flag, irq raise, mask, clear
    v = 4 + rnd() % 8;
    bus(1, OFS_TOP, v);
    bus(1, OFS_MASK, 1);
    bus(1, OFS_CTRL, 1);
    tk(3 * (v + 1));
    chk("irq on", 1, irq);
    chk("ovf events", 1, n_ovf >= 2);
    bus(1, OFS_CTRL, 0);
    bus(1, OFS_MASK, 0);
    tk(2);
    chk("irq masked", 0, irq);
    bus(0, OFS_STATUS, 0);
    chk("status ovf", 1, rd);
    bus(0, OFS_STATUS, 0);
    chk("status clr", 0, rd);
    $display("test overflow done");
    // one compare match at top in one period
    bus(1, OFS_CH_BASE, 32'(MODE_COMPARE));
    bus(1, OFS_CH_BASE + 8'h04, v);
    bus(1, OFS_COUNT, 0);
    o = ch_out[0];
    bus(1, OFS_CTRL, 1);
    tk(v + 1);
    bus(1, OFS_CTRL, 0);
    chk("cmp out", ~o & 1, ch_out[0]);
    bus(0, OFS_STATUS, 0);
    chk("cmp status", 3, rd);
    $display("test compare done");
    // capture on rising edge of pin 1; pin 3 ignores its rise and waits for the fall
    bus(1, OFS_CH_BASE + 8'h08, 32'({EDGE_RISE, MODE_CAPTURE}));
    bus(1, OFS_CH_BASE + 8'h18, 32'({EDGE_FALL, MODE_CAPTURE}));
    v = rnd() & 32'h0000FFFF;
    bus(1, OFS_COUNT, v);
    cap_req <= 4'hA;
    tk(8);
    bus(0, OFS_CH_BASE + 8'h0C, 0);
    chk("capture", v, rd);
    bus(0, OFS_STATUS, 0);
    chk("cap status", 4, rd);
    bus(1, OFS_COUNT, ~v & 32'h0000FFFF);
    cap_req <= 4'h2;
    tk(8);
    bus(0, OFS_CH_BASE + 8'h1C, 0);
    chk("capture fall", ~v & 32'h0000FFFF, rd);
    bus(0, OFS_STATUS, 0);
    chk("fall status", 16, rd);
    $display("test capture done");
    // external event counting
    bus(1, OFS_TOP, 32'h0000FFFF);
    bus(1, OFS_COUNT, 0);
    bus(1, OFS_CTRL, 3);
    cnt_req <= 1;
    tk(40);
    cnt_req <= 0;
    tk(10);
    bus(0, OFS_COUNT, 0);
    chk("ext count", n_edge, rd);
    $display("test events done");
    // pwm follows successive values, then dead time
    bus(1, OFS_TOP, 7);
    bus(1, OFS_CH_BASE + 8'h10, 32'(MODE_PWM));
    for (int k = 0; k < 3; k++) begin
      v = (k == 2) ? 4 : rnd() % 9;
      bus(1, OFS_CH_BASE + 8'h14, v);
      bus(1, OFS_DTIME, 1);
      bus(1, OFS_CTRL, (k == 2) ? 5 : 1);
      tk(20);
      h = 0;
      z = 0;
      for (int i = 0; i < 8; i++) begin
        @(posedge clock);
        h += ch_out[2];
        z += !ch_out[2] && !ch_out_n[2];
      end
      if (k < 2) chk("pwm highs", v, h);
      else chk("dead gap", 4, z);
    end
    $display("test pwm done");
    // clock enable low freezes the counter, which runs 0..7: two ticks between the reads
    bus(0, OFS_COUNT, 0);
    o = rd;
    ce <= 1'b0;
    tk(3 + rnd() % 4);
    ce <= 1'b1;
    bus(0, OFS_COUNT, 0);
    chk("ce freeze", 2, (rd - o) & 32'h00000007);
    $display("test enable done");
    finish_test();
  end
  initial begin
    #200us;
    bad_count++;
    finish_test();
  end
endmodule
